// [design/abm_pkg.sv]
package abm_pkg;
	// ----------------------------------------
	// Function codes
	// ----------------------------------------
	localparam logic [2:0] FC_USER_DATA = 3'h1;
	localparam logic [2:0] FC_USER_PROG = 3'h2;
	localparam logic [2:0] FC_SUPV_DATA = 3'h5;
	localparam logic [2:0] FC_SUPV_PROG = 3'h6;
	localparam logic [2:0] FC_CPU_SPACE = 3'h7;
	// ----------------------------------------
	// Address layout and reset values
	// ----------------------------------------
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int IACK_HI_W = 20;
	localparam logic [19:0] IACK_HI = 20'hfffff;
	localparam logic [7:0] TAS_SET_MASK = 8'h80;
	localparam int SYNC_STAGES = 2;
	localparam logic [15:0] DATA_RST = 16'h0000;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		K_READ,
		K_WRITE,
		K_RMW,
		K_IACK,
		K_BKPT
	} abm_kind_e;
	typedef struct packed {
		abm_kind_e kind;
		logic byte_op;
		logic supervisor;
		logic prog_fetch;
		logic [2:0] level;
		logic [23:0] addr;
		logic [15:0] wdata;
	} abm_req_s;
	typedef struct packed {
		logic [15:0] rdata;
		logic fault;
		logic autovec;
	} abm_rsp_s;
endpackage

// [design/abm_master.sv]
`timescale 1ns/1ns
module abm_master
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Core request and answer
	input wire logic req_valid,
	output logic req_ready,
	input abm_pkg::abm_req_s req,
	output logic rsp_valid,
	output abm_pkg::abm_rsp_s rsp,
	input wire logic core_halt_req,
	input wire logic core_reset_req,
	// Address and data pins
	output logic [23:1] addr_out,
	output logic addr_oe,
	input wire logic [15:0] data_in,
	output logic [15:0] data_out,
	output logic data_oe,
	// Control outputs
	output logic address_strobe_n,
	output logic read_write,
	output logic upper_byte_strobe_n,
	output logic lower_byte_strobe_n,
	output logic sync_mem_valid_n,
	output logic [2:0] function_code,
	output logic ctrl_oe,
	output logic grant_out_n,
	// Slave answers, and the grant confirm of a new master
	input wire logic transfer_ack_n,
	input wire logic bus_fault_in_n,
	input wire logic sync_periph_sel_n,
	input wire logic grant_confirm_n,
	// Open-drain halt and reset
	input wire logic halt_in_n,
	output logic halt_out,
	output logic halt_oe,
	output logic reset_out,
	output logic reset_oe
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_S0, ST_S1, ST_S2, ST_S3, ST_S4, ST_WAIT,
		ST_S5, ST_S6, ST_S7, ST_MOD
	} abm_state_e;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Data passes the same two stages as the acknowledges, so a latch two
	// cycles after recognition sees data that was stable with the ack.
	logic [3:0] ctl_m_q, ctl_s_q;
	logic [3:0] ctl_raw;
	logic [15:0] dat_m_q, dat_s_q;
	logic halt_m_q, halt_s_q;
	assign ctl_raw = {grant_confirm_n, sync_periph_sel_n,
		bus_fault_in_n, transfer_ack_n};
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ctl_m_q <= 4'hf;
			ctl_s_q <= 4'hf;
			halt_m_q <= 1'b1;
			halt_s_q <= 1'b1;
		end
		else
		begin
			ctl_m_q <= ctl_raw;
			ctl_s_q <= ctl_m_q;
			halt_m_q <= halt_in_n;
			halt_s_q <= halt_m_q;
		end
	end
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			dat_m_q <= abm_pkg::DATA_RST;
			dat_s_q <= abm_pkg::DATA_RST;
		end
		else
		begin
			dat_m_q <= data_in;
			dat_s_q <= dat_m_q;
		end
	end

	logic ack_s, fault_s, vpa_s, granted_s, halted_s, term;
	assign ack_s = !ctl_s_q[0];
	assign fault_s = !ctl_s_q[1];
	assign vpa_s = !ctl_s_q[2];
	assign granted_s = !ctl_s_q[3];
	assign halted_s = !halt_s_q;
	assign term = ack_s | fault_s | vpa_s;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	abm_state_e state_q, state_d;
	abm_pkg::abm_req_s cur_q;
	logic wr_phase_q, fault_q, vpa_q;

	function automatic logic is_rmw(input abm_pkg::abm_kind_e k);
		is_rmw = (k == abm_pkg::K_RMW);
	endfunction

	function automatic logic [2:0] fc_of(input abm_pkg::abm_req_s r);
		if (r.kind == abm_pkg::K_IACK || r.kind == abm_pkg::K_BKPT)
			fc_of = abm_pkg::FC_CPU_SPACE;
		else if (r.supervisor && r.prog_fetch)
			fc_of = abm_pkg::FC_SUPV_PROG;
		else if (r.supervisor)
			fc_of = abm_pkg::FC_SUPV_DATA;
		else if (r.prog_fetch)
			fc_of = abm_pkg::FC_USER_PROG;
		else
			fc_of = abm_pkg::FC_USER_DATA;
	endfunction

	assign req_ready = (state_q == ST_IDLE) && !halted_s && !granted_s;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: if (req_valid && req_ready) state_d = ST_S0;
			ST_S0: state_d = ST_S1;
			ST_S1: state_d = ST_S2;
			ST_S2: state_d = ST_S3;
			ST_S3: state_d = ST_S4;
			ST_S4: state_d = term ? ST_S5 : ST_WAIT;
			ST_WAIT: state_d = term ? ST_S5 : ST_WAIT;
			ST_S5: state_d = ST_S6;
			ST_S6: state_d = ST_S7;
			ST_S7:
			begin
				if (is_rmw(cur_q.kind) && !wr_phase_q && !fault_q)
					state_d = ST_MOD;
				else
					state_d = ST_IDLE;
			end
			ST_MOD: state_d = ST_S0;
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Latched request; test-and-set forces a byte access
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			cur_q <= '0;
			wr_phase_q <= 1'b0;
		end
		else if (state_q == ST_IDLE && state_d == ST_S0)
		begin
			cur_q <= req;
			if (is_rmw(req.kind))
				cur_q.byte_op <= 1'b1;
			wr_phase_q <= (req.kind == abm_pkg::K_WRITE);
		end
		else if (state_q == ST_MOD)
		begin
			// Modify step: set the semaphore bit on both lanes
			cur_q.wdata <= rsp.rdata | {abm_pkg::TAS_SET_MASK,
				abm_pkg::TAS_SET_MASK};
			wr_phase_q <= 1'b1;
		end
	end

	// Termination kind
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			fault_q <= 1'b0;
			vpa_q <= 1'b0;
		end
		else if (state_q == ST_S0)
		begin
			fault_q <= 1'b0;
			vpa_q <= 1'b0;
		end
		else if ((state_q == ST_S4 || state_q == ST_WAIT) && term)
		begin
			fault_q <= fault_s;
			vpa_q <= vpa_s && !ack_s;
		end
	end

	// ----------------------------------------
	// Read data and answer
	// ----------------------------------------
	logic reading;
	assign reading = !wr_phase_q && cur_q.kind != abm_pkg::K_BKPT;
	// One process owns the whole answer struct
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			rsp_valid <= 1'b0;
			rsp <= '{abm_pkg::DATA_RST, 1'b0, 1'b0};
		end
		else
		begin
			rsp_valid <= (state_q == ST_S7) && (state_d == ST_IDLE);
			rsp.fault <= fault_q;
			rsp.autovec <= vpa_q;
			if (state_q == ST_S6 && reading)
			begin
				if (!cur_q.byte_op)
					rsp.rdata <= dat_s_q;
				else if (cur_q.addr[0])
					rsp.rdata <= {8'h00, dat_s_q[7:0]};
				else
					rsp.rdata <= {8'h00, dat_s_q[15:8]};
			end
		end
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	// Strobes and enables are registered from the next state, address, code and data in S0,
	// so every edge leaves a flop cleanly; this is the deskew of what the master issues.
	logic busy_d, as_on_d, ds_on_d, hold_as_d;
	assign busy_d = (state_d != ST_IDLE);
	// Strobe held from the read's S7 to the write's S1; keyed on the current
	// state so an idle block never inherits the last test-and-set
	assign hold_as_d = is_rmw(cur_q.kind) && !fault_q &&
		((!wr_phase_q && state_d inside {ST_S7, ST_MOD}) ||
		state_q == ST_MOD || (wr_phase_q && state_q == ST_S0));
	assign as_on_d = hold_as_d || (state_d inside
		{ST_S2, ST_S3, ST_S4, ST_WAIT, ST_S5, ST_S6});
	assign ds_on_d = (wr_phase_q ? (state_d inside
		{ST_S4, ST_WAIT, ST_S5, ST_S6}) : (state_d inside
		{ST_S2, ST_S3, ST_S4, ST_WAIT, ST_S5, ST_S6}))
		&& cur_q.kind != abm_pkg::K_BKPT;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			addr_out <= '0;
			function_code <= abm_pkg::FC_USER_DATA;
			read_write <= 1'b1;
			address_strobe_n <= 1'b1;
			upper_byte_strobe_n <= 1'b1;
			lower_byte_strobe_n <= 1'b1;
			data_out <= abm_pkg::DATA_RST;
			data_oe <= 1'b0;
		end
		else
		begin
			if (state_q == ST_S0)
			begin
				function_code <= fc_of(cur_q);
				if (cur_q.kind == abm_pkg::K_IACK)
					addr_out <= {abm_pkg::IACK_HI, cur_q.level};
				else if (cur_q.kind == abm_pkg::K_BKPT)
					addr_out <= '0;
				else
					addr_out <= cur_q.addr[23:1];
				read_write <= !wr_phase_q;
				data_out <= cur_q.byte_op ? {cur_q.wdata[7:0],
					cur_q.wdata[7:0]} : cur_q.wdata;
			end
			else if (state_d == ST_IDLE)
				read_write <= 1'b1;
			address_strobe_n <= !as_on_d;
			upper_byte_strobe_n <= !(ds_on_d &&
				(!cur_q.byte_op || !cur_q.addr[0]));
			lower_byte_strobe_n <= !(ds_on_d &&
				(!cur_q.byte_op || cur_q.addr[0]));
			data_oe <= wr_phase_q && busy_d &&
				!(state_d inside {ST_S0, ST_S1});
		end
	end

	// Float: halt frees address and data; a new master frees controls too
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			addr_oe <= 1'b1;
			ctrl_oe <= 1'b1;
		end
		else
		begin
			addr_oe <= busy_d || !(halted_s || granted_s);
			ctrl_oe <= busy_d || !granted_s;
		end
	end

	// Synchronous peripheral transfers are not run here; grant is driven
	// inactive by this block and the arbiter owns the real grant timing.
	assign sync_mem_valid_n = 1'b1;
	assign grant_out_n = 1'b1;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			halt_oe <= 1'b0;
			reset_oe <= 1'b0;
		end
		else
		begin
			halt_oe <= core_halt_req;
			reset_oe <= core_reset_req;
		end
	end
	assign halt_out = 1'b0;
	assign reset_out = 1'b0;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	fc_code_legal_a: assert property (!address_strobe_n |->
		!(function_code inside {3'h0, 3'h3, 3'h4}))
		else $error("reserved function code issued");
	fc_hold_a: assert property (!address_strobe_n &&
		$past(!address_strobe_n) |-> $stable(function_code))
		else $error("function code changed under strobe");
	word_lanes_a: assert property (!cur_q.byte_op &&
		!upper_byte_strobe_n |-> !lower_byte_strobe_n)
		else $error("word access missing a lane");
	byte_lane_a: assert property (cur_q.byte_op &&
		!address_strobe_n |-> !(upper_byte_strobe_n ==
		lower_byte_strobe_n && !upper_byte_strobe_n))
		else $error("byte access strobed both lanes");
	wait_hold_a: assert property (state_q == ST_S4 && !term
		|=> state_q == ST_WAIT)
		else $error("no wait inserted without termination");
	halt_float_a: assert property (state_q == ST_IDLE &&
		halted_s && state_d == ST_IDLE |=> !addr_oe && !data_oe)
		else $error("buses not floated on halt");
	grant_float_a: assert property (state_q == ST_IDLE &&
		granted_s && state_d == ST_IDLE |=> !ctrl_oe)
		else $error("controls not floated on grant confirm");
	rmw_strobe_a: assert property (state_q == ST_MOD
		|-> !address_strobe_n ##1 !address_strobe_n[*2])
		else $error("strobe released inside test-and-set");
	iack_addr_a: assert property (!address_strobe_n &&
		cur_q.kind == abm_pkg::K_IACK |-> &addr_out[23:4])
		else $error("acknowledge address wrong");
	bkpt_addr_a: assert property (!address_strobe_n &&
		cur_q.kind == abm_pkg::K_BKPT |-> addr_out == '0 &&
		upper_byte_strobe_n && lower_byte_strobe_n)
		else $error("breakpoint address or strobe wrong");
	latch_time_a: assert property (state_q == ST_S4 && term &&
		(wr_phase_q || !is_rmw(cur_q.kind))
		|-> ##4 rsp_valid && state_q == ST_IDLE)
		else $error("cycle end timing wrong");

	word_read_c: cover property (state_q == ST_S7 && !cur_q.byte_op
		&& !wr_phase_q);
	wait_seen_c: cover property (state_q == ST_WAIT ##1 state_q == ST_S5);
	rmw_done_c: cover property (state_q == ST_MOD ##[1:40] rsp_valid);
	iack_done_c: cover property (cur_q.kind == abm_pkg::K_IACK &&
		rsp_valid);
endmodule // abm_master

// [testbench/abm_slave_model.sv]
`timescale 1ns/1ns
module abm_slave_model
(
	// Clock
	input wire logic mclk,
	// Bus from the master
	input wire logic [23:1] addr_out,
	input wire logic address_strobe_n,
	input wire logic read_write,
	input wire logic upper_byte_strobe_n,
	input wire logic lower_byte_strobe_n,
	input wire logic [15:0] data_out,
	// Answers to the master
	output logic [15:0] data_in,
	output logic transfer_ack_n,
	output logic bus_fault_in_n,
	output logic sync_periph_sel_n,
	// Behaviour chosen by the bench
	input wire logic [3:0] wait_cycles,
	input wire logic [1:0] mode,
	input wire logic [7:0] vector
);
	logic [15:0] mem [logic [22:0]];
	logic [3:0] cnt_q = 4'h0;
	logic term_q = 1'b0;
	logic [15:0] last_q = 16'h0000;
	logic [15:0] old_w;
	logic sel;
	logic cpu_ack;
	// ----------------------------------------
	// Decode and termination
	// ----------------------------------------
	function automatic logic [15:0] rd(logic [22:0] a);
		return mem.exists(a) ? mem[a] : 16'h0000;
	endfunction
	// Upper address bits tell the acknowledge kinds apart
	assign cpu_ack = !address_strobe_n && (&addr_out[23:4]);
	assign sel = !upper_byte_strobe_n || !lower_byte_strobe_n || cpu_ack
		|| (!address_strobe_n && addr_out == 23'h0);
	// Delay before answering forces wait states in the master
	always @(posedge mclk)
	begin
		if (!sel)
		begin
			cnt_q <= 4'h0;
			term_q <= 1'b0;
		end
		else if (cnt_q >= wait_cycles)
			term_q <= 1'b1;
		else
			cnt_q <= cnt_q + 4'h1;
	end
	assign transfer_ack_n = !(term_q && mode == 2'h0);
	assign bus_fault_in_n = !(term_q && mode == 2'h1);
	assign sync_periph_sel_n = !(term_q && mode == 2'h2);
	// Lanes follow the strobes; a faulted cycle writes nothing
	always @(posedge mclk)
	begin
		last_q <= data_in;
		if (term_q && sel && mode == 2'h0 && !read_write)
		begin
			old_w = rd(addr_out);
			mem[addr_out] = {
				upper_byte_strobe_n ? old_w[15:8] : data_out[15:8],
				lower_byte_strobe_n ? old_w[7:0] : data_out[7:0]};
		end
	end
	// Released bus inverts every cycle, so the old data comes back every other cycle
	always @*
	begin
		if (sel && read_write)
			data_in = cpu_ack ? {vector, vector} : rd(addr_out);
		else
			data_in = ~last_q;
	end
endmodule // abm_slave_model

// [testbench/tb_async_bus_master_cycles.sv]
`timescale 1ns/1ns
module tb_async_bus_master_cycles;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	abm_pkg::abm_req_s req = '0;
	logic core_halt_req = 1'b0;
	logic core_reset_req = 1'b0;
	logic halt_in_n = 1'b1;
	logic grant_confirm_n = 1'b1;
	logic [3:0] wait_cycles = 4'h0;
	logic [1:0] mode = 2'h0;
	logic [7:0] vector = 8'h00;
	logic req_ready, rsp_valid, addr_oe, data_oe, ctrl_oe, grant_out_n;
	logic halt_oe, reset_oe, address_strobe_n, read_write, transfer_ack_n;
	logic upper_byte_strobe_n, lower_byte_strobe_n, bus_fault_in_n;
	logic sync_periph_sel_n;
	abm_pkg::abm_rsp_s rsp;
	logic [23:1] addr_out;
	logic [15:0] data_in, data_out;
	logic [2:0] function_code;
	int mismatches = 0;
	int checks = 0;
	int rises = 0;
	logic [31:0] seed = 32'd81;
	logic [15:0] shadow [logic [22:0]];
	logic [2:0] e_fc;
	logic [23:1] e_addr;
	logic [1:0] e_strb;
	logic [15:0] e_wd;
	logic e_strb_en, mon = 1'b0, as_q = 1'b1;
	abm_master dut
	(
		.mclk, .rst_n, .req_valid, .req_ready, .req, .rsp_valid, .rsp,
		.core_halt_req, .core_reset_req, .addr_out, .addr_oe,
		.data_in, .data_out, .data_oe, .address_strobe_n, .read_write,
		.upper_byte_strobe_n, .lower_byte_strobe_n, .sync_mem_valid_n(),
		.function_code, .ctrl_oe, .grant_out_n, .transfer_ack_n,
		.bus_fault_in_n, .sync_periph_sel_n, .grant_confirm_n, .halt_in_n,
		.halt_out(), .halt_oe, .reset_out(), .reset_oe
	);
	abm_slave_model slave
	(
		.mclk, .addr_out, .address_strobe_n, .read_write,
		.upper_byte_strobe_n, .lower_byte_strobe_n, .data_out, .data_in,
		.transfer_ack_n, .bus_fault_in_n, .sync_periph_sel_n,
		.wait_cycles, .mode, .vector
	);
	// Free-running clock, never gated
	always #2 mclk = ~mclk;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [15:0] peek(logic [22:0] a);
		return shadow.exists(a) ? shadow[a] : 16'h0000;
	endfunction
	function automatic logic [2:0] fc_of(abm_pkg::abm_kind_e k, logic s,
		logic p);
		if (k == abm_pkg::K_IACK || k == abm_pkg::K_BKPT)
			return 3'h7;
		return {s, p, !p};
	endfunction
	task automatic chk_rsp(logic [23:0] got, logic [23:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error %0t: answer %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(logic [23:0] got, logic [23:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error %0t: pins %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		if (mismatches == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Pins watched while the address strobe is low
	always @(negedge mclk)
	begin
		if (mon && !address_strobe_n)
		begin
			chk_pin(24'(function_code), 24'(e_fc));
			chk_pin(24'(addr_out), 24'(e_addr));
			if (e_strb_en && !(upper_byte_strobe_n && lower_byte_strobe_n))
				chk_pin(24'({upper_byte_strobe_n, lower_byte_strobe_n}),
					24'(e_strb));
			if (!read_write && !(upper_byte_strobe_n && lower_byte_strobe_n))
				chk_pin(24'(data_out), 24'(e_wd));
		end
		if (mon && address_strobe_n && !as_q)
			rises++;
		as_q = address_strobe_n;
	end
	// ----------------------------------------
	// One bus cycle, start to answer
	// ----------------------------------------
	task automatic run(abm_pkg::abm_kind_e k, logic b, logic [2:0] lv,
		logic [23:0] a, logic [15:0] wd, logic [1:0] md, logic [3:0] wt);
		logic [15:0] old, exp;
		logic [7:0] ob;
		logic [31:0] r;
		int n;
		old = peek(a[23:1]);
		ob = a[0] ? old[7:0] : old[15:8];
		r = rnd();
		if (k == abm_pkg::K_RMW)
			wd = {8'h00, ob | abm_pkg::TAS_SET_MASK};
		@(posedge mclk);
		#1;
		req = '{k, b, r[0], r[1], lv, a, wd};
		vector = r[15:8];
		wait_cycles = wt;
		mode = md;
		req_valid = 1'b1;
		e_fc = fc_of(k, r[0], r[1]);
		e_addr = k == abm_pkg::K_IACK ? {abm_pkg::IACK_HI, lv} :
			(k == abm_pkg::K_BKPT ? 23'h0 : a[23:1]);
		e_strb_en = k != abm_pkg::K_IACK && k != abm_pkg::K_BKPT;
		e_strb = !b ? 2'b00 : (a[0] ? 2'b10 : 2'b01);
		e_wd = b ? {wd[7:0], wd[7:0]} : wd;
		rises = 0;
		mon = 1'b1;
		for (n = 0; n < 50 && req_ready !== 1'b1; n++)
			@(negedge mclk);
		@(posedge mclk);
		#1;
		req_valid = 1'b0;
		for (n = 0; n < 100 && rsp_valid !== 1'b1; n++)
			@(negedge mclk);
		chk_rsp(24'(rsp_valid), 24'h1);
		exp = k == abm_pkg::K_IACK ? {8'h00, vector} : (b ? {8'h00, ob} : old);
		if (k != abm_pkg::K_WRITE && k != abm_pkg::K_BKPT && md == 2'h0)
			chk_rsp(24'(b || k == abm_pkg::K_IACK ? {8'h00, rsp.rdata[7:0]} :
				rsp.rdata), 24'(exp));
		chk_rsp(24'({rsp.fault, rsp.autovec}),
			24'({md == 2'h1, md == 2'h2}));
		chk_pin(24'(rises), 24'h1);
		mon = 1'b0;
		if (md == 2'h0 && (k == abm_pkg::K_WRITE || k == abm_pkg::K_RMW))
			shadow[a[23:1]] = !b ? wd : (a[0] ? {old[15:8], wd[7:0]} :
				{wd[7:0], old[7:0]});
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] r;
		repeat (3) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		repeat (2) @(posedge mclk);
		// Random words and bytes, back to back, with waits and faults
		for (int i = 0; i < 80; i++)
		begin
			r = rnd();
			run(r[0] ? abm_pkg::K_WRITE : abm_pkg::K_READ, r[1], 3'h0,
				{16'h0001, r[15:8]}, r[31:16],
				(!r[0] && r[5:4] == 2'h3) ? 2'(r[6]) + 2'h1 : 2'h0, 4'(r[3:2]));
		end
		// Test-and-set on both lanes, slow and fast, then one faulted
		run(abm_pkg::K_RMW, 1'b1, 3'h0, 24'h000120, 16'h0, 2'h0, 4'h3);
		run(abm_pkg::K_RMW, 1'b1, 3'h0, 24'h000121, 16'h0, 2'h0, 4'h0);
		run(abm_pkg::K_READ, 1'b0, 3'h0, 24'h000120, 16'h0, 2'h0, 4'h1);
		run(abm_pkg::K_RMW, 1'b1, 3'h0, 24'h000122, 16'h0, 2'h1, 4'h1);
		// Acknowledge levels 1 to 7, and breakpoints with each ending
		for (int l = 1; l < 8; l++)
			run(abm_pkg::K_IACK, 1'b1, 3'(l), 24'h0, 16'h0, 2'h0,
				4'(l % 3));
		for (int m = 0; m < 3; m++)
			run(abm_pkg::K_BKPT, 1'b0, 3'h0, 24'h0, 16'h0, 2'(m), 4'h1);
		// Halt floats only address and data
		@(posedge mclk);
		#1;
		halt_in_n = 1'b0;
		core_halt_req = 1'b1;
		core_reset_req = 1'b1;
		repeat (4) @(negedge mclk);
		chk_pin(24'({addr_oe, data_oe, ctrl_oe, req_ready, halt_oe,
			reset_oe}), 24'h0b);
		#1;
		halt_in_n = 1'b1;
		core_halt_req = 1'b0;
		core_reset_req = 1'b0;
		grant_confirm_n = 1'b0;
		repeat (4) @(negedge mclk);
		chk_pin(24'({addr_oe, data_oe, ctrl_oe, grant_out_n, reset_oe}),
			24'h02);
		#1;
		grant_confirm_n = 1'b1;
		repeat (4) @(posedge mclk);
		run(abm_pkg::K_READ, 1'b0, 3'h0, 24'h000120, 16'h0, 2'h0, 4'h0);
		wrap_up();
	end
	// Watchdog well beyond the expected run length
	initial
	begin
		#80000;
		mismatches++;
		wrap_up();
	end
endmodule // tb_async_bus_master_cycles
